/* File: hdl/ps2_host_consts.vh */
// Constants for the PS/2 host port controller
`ifndef PS2_HOST_CONSTS_VH
`define PS2_HOST_CONSTS_VH

`define CLK_MHZ 18'h0000A

// Register offsets (byte addresses, one word each)
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_RXDATA 8'h08
`define OFF_TXDATA 8'h0C
`define OFF_LEDS 8'h10
`define OFF_RATE 8'h14
`define OFF_KEY 8'h18
`define OFF_MOUSE 8'h1C

// Control fields and reset value
`define CTRL_MOUSE 0
`define CTRL_INHIBIT 1
`define CTRL_RST 2'h0

// Status fields
`define ST_RX_NEW 0
`define ST_RX_ERR 1
`define ST_TX_BUSY 2
`define ST_TX_NOACK 3
`define ST_KEY_NEW 4
`define ST_MOUSE_NEW 5
`define ST_ACK 6
`define ST_ECHO 7
`define ST_RST 8'h00

// Mouse status byte fields
`define MS_LEFT 0
`define MS_RIGHT 1
`define MS_XSIGN 4
`define MS_YSIGN 5
`define MS_XOVF 6
`define MS_YOVF 7

// Link bytes
`define CODE_EXT 8'hE0
`define CODE_BREAK 8'hF0
`define CODE_ACK 8'hFA
`define CODE_LEDS 8'hED
`define CODE_ECHO 8'hEE
`define CODE_RATE 8'hF3
`define CODE_RESEND 8'hFE

// Timing
`define HOLD_US 18'h00064
`define HOLD_CYC (`HOLD_US * `CLK_MHZ)
`define RX_GAP_US 18'h000C8
`define RX_GAP_CYC (`RX_GAP_US * `CLK_MHZ)
`define TX_WAIT_US 18'h03A98
`define TX_WAIT_CYC (`TX_WAIT_US * `CLK_MHZ)

`endif

/* File: hdl/ps2_host_port.v */
// PS/2 host port: receiver, transmitter, decoders and APB registers
`timescale 1ns/10ps
`default_nettype none
`include "ps2_host_consts.vh"

module ps2_host_port #(
  parameter TX_WAIT_CYCLES = `TX_WAIT_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ps2_clk_in,
  output wire ps2_clk_out,
  output wire ps2_clk_oe,
  input wire ps2_data_in,
  output wire ps2_data_out,
  output wire ps2_data_oe
);

  localparam [17:0] HOLD_CYC = `HOLD_CYC;
  localparam [17:0] RX_GAP_CYC = `RX_GAP_CYC;
  localparam [17:0] TX_WAIT = TX_WAIT_CYCLES;

  localparam [2:0] T_IDLE = 3'h0;
  localparam [2:0] T_HOLD = 3'h1;
  localparam [2:0] T_START = 3'h2;
  localparam [2:0] T_BITS = 3'h3;
  localparam [2:0] T_ACK = 3'h4;
  localparam [2:0] T_END = 3'h5;

  reg [1:0] ctrl;
  reg [7:0] status;
  reg [7:0] rx_data;
  reg [7:0] tx_last;
  reg [2:0] leds;
  reg [7:0] rate;
  reg [9:0] key;
  reg [21:0] mouse;

  reg clk_s1, clk_s2, clk_s3;
  reg dat_s1, dat_s2;
  wire clk_fall;

  reg [3:0] rx_cnt;
  reg [10:0] rx_shift;
  reg [17:0] rx_gap;
  reg rx_ok;
  reg rx_bad;

  reg [2:0] tx_state;
  reg [3:0] tx_cnt;
  reg [8:0] tx_frame;
  reg tx_low;
  reg [17:0] tx_timer;
  reg tx_fail;
  reg tx_go;
  reg [7:0] tx_byte;

  reg pend;
  reg [7:0] pend_byte;
  reg ext_pend;
  reg brk_pend;
  reg [1:0] m_idx;
  reg [7:0] m_stat;
  reg [7:0] m_x;
  reg key_set;
  reg mouse_set;

  wire inhibit;
  wire tx_busy;
  wire addr_hit;
  wire wr;
  wire [7:0] st_clr;
  wire [7:0] st_set;
  reg [31:0] rd_mux;

  assign inhibit = ctrl[`CTRL_INHIBIT];
  assign tx_busy = (tx_state != T_IDLE);

  // Lines are only ever pulled low; released means high
  assign ps2_clk_out = 1'b0;
  assign ps2_data_out = 1'b0;
  // Clock held low for inhibit or a send request
  assign ps2_clk_oe = inhibit | (tx_state == T_HOLD) |
                      (tx_state == T_START);
  assign ps2_data_oe = tx_low;

  // Two-stage synchronisers, edge found on the synchronised copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_s3 <= 1'b1;
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
    end else begin
      clk_s1 <= ps2_clk_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= ps2_data_in;
      dat_s2 <= dat_s1;
    end
  end

  assign clk_fall = clk_s3 & ~clk_s2;

  // Receiver: shift on each falling edge, rate set by the peripheral
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 4'h0;
      rx_shift <= 11'h000;
      rx_gap <= 18'h00000;
      rx_ok <= 1'b0;
      rx_bad <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_ok <= 1'b0;
      rx_bad <= 1'b0;
      if (tx_busy || inhibit) begin
        rx_cnt <= 4'h0;
        rx_gap <= 18'h00000;
      end else if (clk_fall) begin
        rx_gap <= 18'h00000;
        rx_shift <= {dat_s2, rx_shift[10:1]};
        if (rx_cnt == 4'hA) begin
          rx_cnt <= 4'h0;
          // Frame: [0] start, [8:1] data, [9] parity, [10] stop
          if (!rx_shift[1] && dat_s2 && (^rx_shift[10:2])) begin
            rx_ok <= 1'b1;
            rx_data <= rx_shift[9:2];
          end else begin
            rx_bad <= 1'b1;
          end
        end else begin
          rx_cnt <= rx_cnt + 4'h1;
        end
      end else if (rx_cnt != 4'h0) begin
        // A stalled frame is dropped so the next one aligns
        if (rx_gap == RX_GAP_CYC) begin
          rx_cnt <= 4'h0;
          rx_gap <= 18'h00000;
          rx_bad <= 1'b1;
        end else begin
          rx_gap <= rx_gap + 18'h00001;
        end
      end
    end
  end

  // Transmitter: hold clock, start bit, data on falling edges, ack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= T_IDLE;
      tx_cnt <= 4'h0;
      tx_frame <= 9'h000;
      tx_low <= 1'b0;
      tx_timer <= 18'h00000;
      tx_fail <= 1'b0;
      tx_last <= 8'h00;
    end else begin
      tx_fail <= 1'b0;
      case (tx_state)
        T_IDLE: begin
          tx_low <= 1'b0;
          if (tx_go) begin
            tx_frame <= {~(^tx_byte), tx_byte};
            tx_last <= tx_byte;
            tx_timer <= 18'h00000;
            tx_state <= T_HOLD;
          end
        end
        T_HOLD: begin
          if (tx_timer == HOLD_CYC) begin
            tx_low <= 1'b1;
            tx_state <= T_START;
          end else begin
            tx_timer <= tx_timer + 18'h00001;
          end
        end
        T_START: begin
          tx_cnt <= 4'h0;
          tx_timer <= 18'h00000;
          tx_state <= T_BITS;
        end
        T_BITS: begin
          if (clk_fall) begin
            tx_timer <= 18'h00000;
            if (tx_cnt == 4'h9) begin
              tx_low <= 1'b0;
              tx_state <= T_ACK;
            end else begin
              tx_low <= ~tx_frame[tx_cnt];
              tx_cnt <= tx_cnt + 4'h1;
            end
          end else if (tx_timer == TX_WAIT) begin
            tx_low <= 1'b0;
            tx_fail <= 1'b1;
            tx_state <= T_IDLE;
          end else begin
            tx_timer <= tx_timer + 18'h00001;
          end
        end
        T_ACK: begin
          if (clk_fall) begin
            tx_fail <= dat_s2;
            tx_state <= T_END;
          end else if (tx_timer == TX_WAIT) begin
            tx_fail <= 1'b1;
            tx_state <= T_IDLE;
          end else begin
            tx_timer <= tx_timer + 18'h00001;
          end
        end
        T_END: begin
          if (clk_s2 && dat_s2) begin
            tx_state <= T_IDLE;
          end
        end
        default: begin
          tx_low <= 1'b0;
          tx_state <= T_IDLE;
        end
      endcase
    end
  end

  // Decoders and the two-byte command sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
      pend_byte <= 8'h00;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
      ext_pend <= 1'b0;
      brk_pend <= 1'b0;
      key <= 10'h000;
      key_set <= 1'b0;
      m_idx <= 2'h0;
      m_stat <= 8'h00;
      m_x <= 8'h00;
      mouse <= 22'h000000;
      mouse_set <= 1'b0;
    end else begin
      key_set <= 1'b0;
      mouse_set <= 1'b0;
      if (tx_busy) begin
        tx_go <= 1'b0;
      end
      if (wr && !tx_busy && !tx_go && !pend) begin
        if (paddr == `OFF_TXDATA) begin
          // Echo, resend and reset go out as plain bytes
          tx_go <= 1'b1;
          tx_byte <= pwdata[7:0];
        end else if (paddr == `OFF_LEDS) begin
          tx_go <= 1'b1;
          tx_byte <= `CODE_LEDS;
          pend <= 1'b1;
          pend_byte <= {5'h00, pwdata[2:0]};
        end else if (paddr == `OFF_RATE) begin
          tx_go <= 1'b1;
          tx_byte <= `CODE_RATE;
          pend <= 1'b1;
          pend_byte <= pwdata[7:0];
        end
      end
      if (rx_ok && pend && !tx_busy && !tx_go) begin
        pend <= 1'b0;
        if (rx_data == `CODE_ACK) begin
          tx_go <= 1'b1;
          tx_byte <= pend_byte;
        end
      end
      if (tx_fail) begin
        pend <= 1'b0;
      end
      if (rx_bad) begin
        m_idx <= 2'h0;
      end else if (rx_ok && ctrl[`CTRL_MOUSE]) begin
        case (m_idx)
          2'h0: begin
            m_stat <= rx_data;
            m_idx <= 2'h1;
          end
          2'h1: begin
            m_x <= rx_data;
            m_idx <= 2'h2;
          end
          default: begin
            m_idx <= 2'h0;
            mouse_set <= 1'b1;
            mouse[8:0] <= {m_stat[`MS_XSIGN], m_x};
            mouse[17:9] <= {m_stat[`MS_YSIGN], rx_data};
            mouse[18] <= m_stat[`MS_LEFT];
            mouse[19] <= m_stat[`MS_RIGHT];
            mouse[20] <= m_stat[`MS_XOVF];
            mouse[21] <= m_stat[`MS_YOVF];
          end
        endcase
      end else if (rx_ok) begin
        if (rx_data == `CODE_EXT) begin
          ext_pend <= 1'b1;
        end else if (rx_data == `CODE_BREAK) begin
          brk_pend <= 1'b1;
        end else if (rx_data != `CODE_ACK && rx_data != `CODE_ECHO &&
                     rx_data != `CODE_RESEND) begin
          // Held keys repeat as fresh make codes
          key <= {ext_pend, brk_pend, rx_data};
          key_set <= 1'b1;
          ext_pend <= 1'b0;
          brk_pend <= 1'b0;
        end
      end
    end
  end

  // APB slave: zero wait states, read data captured at setup
  assign addr_hit = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign wr = psel & penable & pwrite & addr_hit;

  assign st_clr = (wr && paddr == `OFF_STATUS) ? pwdata[7:0] : 8'h00;
  assign st_set = {rx_ok && rx_data == `CODE_ECHO,
                   rx_ok && rx_data == `CODE_ACK,
                   mouse_set, key_set, tx_fail, 1'b0, rx_bad, rx_ok};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RST;
      status <= `ST_RST;
      leds <= 3'h0;
      rate <= 8'h00;
    end else begin
      // An event in the clearing cycle survives the clear
      status <= (status & ~st_clr) | st_set;
      status[`ST_TX_BUSY] <= tx_busy | tx_go | pend;
      if (wr && paddr == `OFF_CTRL) begin
        ctrl <= pwdata[1:0];
      end
      if (wr && paddr == `OFF_LEDS && !tx_busy && !tx_go && !pend) begin
        leds <= pwdata[2:0];
      end
      if (wr && paddr == `OFF_RATE && !tx_busy && !tx_go && !pend) begin
        rate <= pwdata[7:0];
      end
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `OFF_CTRL: rd_mux = {30'h00000000, ctrl};
      `OFF_STATUS: rd_mux = {24'h000000, status};
      `OFF_RXDATA: rd_mux = {24'h000000, rx_data};
      `OFF_TXDATA: rd_mux = {24'h000000, tx_last};
      `OFF_LEDS: rd_mux = {29'h00000000, leds};
      `OFF_RATE: rd_mux = {24'h000000, rate};
      `OFF_KEY: rd_mux = {22'h000000, key};
      `OFF_MOUSE: rd_mux = {10'h000, mouse};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule // ps2_host_port
`default_nettype wire

/* File: verification/ps2_host_port_checker.sv */
// Assertion checker for the PS/2 host port
`timescale 1ns/10ps
`default_nettype none
module ps2_host_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ps2_clk_in,
  input wire logic ps2_clk_out,
  input wire logic ps2_clk_oe,
  input wire logic ps2_data_in,
  input wire logic ps2_data_out,
  input wire logic ps2_data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_open_drain_low: assert property (!ps2_clk_out && !ps2_data_out)
    else $error("link outputs not low");
  a_clk_hold_min: assert property ($rose(ps2_clk_oe) |=> ps2_clk_oe [*8])
    else $error("clock hold too short");
  a_clk_from_idle: assert property ($rose(ps2_clk_oe) |-> $past(ps2_clk_in))
    else $error("clock pulled mid frame");
  a_data_under_clk: assert property ($rose(ps2_data_oe) |->
    $past(ps2_clk_oe) || !$past(ps2_clk_in))
    else $error("data pulled with clock free");
  a_data_after_fall: assert property
    ($changed(ps2_data_oe) && !ps2_clk_oe |-> !ps2_clk_in)
    else $error("data changed while clock high");
  a_clk_after_data: assert property
    ($fell(ps2_clk_oe) && ps2_data_oe |-> $past(ps2_data_oe))
    else $error("clock released before data");
  a_unmapped_error: assert property (psel && penable &&
    (paddr > 8'h1F || paddr[1:0] != 2'h0) |-> pslverr && pready)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (psel && penable && paddr < 8'h20 &&
    paddr[1:0] == 2'h0 |-> !pslverr && pready)
    else $error("mapped access refused");
  cover property ($rose(ps2_data_oe));
  cover property (psel && penable && pslverr);
  cover property ($fell(ps2_clk_in) && !ps2_clk_oe);
endmodule // ps2_host_port_checker

bind ps2_host_port ps2_host_port_checker chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .ps2_clk_in, .ps2_clk_out, .ps2_clk_oe, .ps2_data_in, .ps2_data_out,
  .ps2_data_oe);
`default_nettype wire

/* File: verification/ps2_dev_model.sv */
// Behavioural PS/2 keyboard or mouse on the far side of the link
`timescale 1ns/10ps
`default_nettype none
module ps2_dev_model (
  input wire logic clk_w,
  input wire logic data_w,
  output logic clk_oe,
  output logic data_oe
);
  logic [7:0] cmds [0:7];
  logic [7:0] last;
  logic [10:0] f;
  logic busy;
  int ncmd;
  initial begin
    clk_oe = 1'h0;
    data_oe = 1'h0;
    busy = 1'h0;
    last = 8'h00;
    ncmd = 0;
  end
  task automatic send_byte(input logic [7:0] b, input logic bad);
    f = {1'h1, ~^b ^ bad, b, 1'h0};
    wait (clk_w && data_w);
    for (int i = 0; i < 11; i++) begin
      data_oe <= !f[i];
      #200 clk_oe <= 1'h1;
      #400 clk_oe <= 1'h0;
      #200;
    end
    data_oe <= 1'h0;
    last = b;
  endtask
  // Host request: data pulled low under a held clock
  always @(negedge data_w) begin
    if (!clk_w && !busy) begin
      busy = 1'h1;
      wait (clk_w);
      for (int i = 0; i < 11; i++) begin
        if (i == 10)
          data_oe <= 1'h1;
        #400 clk_oe <= 1'h1;
        #400 clk_oe <= 1'h0;
        f[i] = data_w;
      end
      #400 data_oe <= 1'h0;
      cmds[ncmd[2:0]] = f[7:0];
      ncmd++;
      #2000;
      if (f[7:0] == 8'hFE)
        send_byte(last, 1'h0);
      else if (f[7:0] == 8'hEE)
        send_byte(8'hEE, 1'h0);
      else
        send_byte(8'hFA, 1'h0);
      busy = 1'h0;
    end
  end
endmodule // ps2_dev_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the PS/2 host port
`timescale 1ns/10ps
`default_nettype none
`include "ps2_host_consts.vh"
module tb_top;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic c_oe, d_oe, c_out, d_out, m_c_oe, m_d_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire logic clk_w, data_w;
  int fail_count = 0;
  int n_compared = 0;
  assign clk_w = !(c_oe || m_c_oe);
  assign data_w = !(d_oe || m_d_oe);
  always #50 pclk = ~pclk;
  ps2_host_port #(.TX_WAIT_CYCLES(18'h00BB8)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ps2_clk_in(clk_w), .ps2_clk_out(c_out), .ps2_clk_oe(c_oe),
    .ps2_data_in(data_w), .ps2_data_out(d_out), .ps2_data_oe(d_oe));
  ps2_dev_model dev (.clk_w, .data_w, .clk_oe(m_c_oe), .data_oe(m_d_oe));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic snd(input logic [7:0] b);
    dev.send_byte(b, 1'h0);
    repeat (5) @(posedge pclk);
  endtask
  task automatic wait_dev(input int n);
    while (dev.ncmd < n || dev.busy)
      @(posedge pclk);
    repeat (5) @(posedge pclk);
  endtask
  task automatic t_reset;
    chk({30'h0, clk_w, data_w}, 32'h3);
    rchk(`OFF_CTRL, 32'h0);
    rchk(`OFF_STATUS, 32'h0);
    rchk(8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_keys;
    snd(8'h1C);
    rchk(`OFF_KEY, 32'h01C);
    snd(8'h1C);
    rchk(`OFF_KEY, 32'h01C);
    snd(8'hF0);
    snd(8'h1C);
    rchk(`OFF_KEY, 32'h11C);
    snd(8'hE0);
    snd(8'h74);
    rchk(`OFF_KEY, 32'h274);
    snd(8'hE0);
    snd(8'hF0);
    snd(8'h74);
    rchk(`OFF_KEY, 32'h374);
    rchk(`OFF_STATUS, 32'h11);
    apb(1'h1, `OFF_STATUS, 32'hFF);
    dev.send_byte(8'h5A, 1'h1);
    repeat (5) @(posedge pclk);
    rchk(`OFF_STATUS, 32'h02);
    rchk(`OFF_RXDATA, 32'h74);
  endtask
  task automatic t_inhibit;
    apb(1'h1, `OFF_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    fork
      dev.send_byte(8'h11, 1'h0);
    join_none
    repeat (50) @(posedge pclk);
    chk({30'h0, clk_w, data_w}, 32'h1);
    apb(1'h1, `OFF_CTRL, 32'h0);
    repeat (200) @(posedge pclk);
    rchk(`OFF_KEY, 32'h011);
  endtask
  task automatic t_cmds;
    apb(1'h1, `OFF_STATUS, 32'hFF);
    apb(1'h1, `OFF_LEDS, 32'hFD);
    wait_dev(2);
    chk({dev.cmds[0], dev.cmds[1]}, 32'hED05);
    rchk(`OFF_LEDS, 32'h5);
    apb(1'h1, `OFF_RATE, 32'h2B);
    wait_dev(4);
    chk({dev.cmds[2], dev.cmds[3]}, 32'hF32B);
    rchk(`OFF_RATE, 32'h2B);
    apb(1'h1, `OFF_STATUS, 32'hFF);
    apb(1'h1, `OFF_TXDATA, 32'hEE);
    wait_dev(5);
    apb(1'h0, `OFF_STATUS, 32'h0);
    chk(rd, 32'h81);
    snd(8'h2A);
    apb(1'h1, `OFF_STATUS, 32'hFF);
    apb(1'h1, `OFF_TXDATA, 32'hFE);
    wait_dev(6);
    apb(1'h0, `OFF_STATUS, 32'h0);
    chk(rd, 32'h11);
    rchk(`OFF_KEY, 32'h02A);
  endtask
  task automatic mpkt(input logic [7:0] st, input logic [7:0] x,
    input logic [7:0] y);
    snd(st);
    snd(x);
    snd(y);
    apb(1'h0, `OFF_MOUSE, 32'h0);
    chk(rd, {10'h0, st[7:6], st[1:0], st[5], y, st[4], x});
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_keys;
    t_inhibit;
    t_cmds;
    apb(1'h1, `OFF_CTRL, 32'h1);
    mpkt(8'h39, 8'hF0, 8'h05);
    mpkt(8'hC2, 8'h7F, 8'h80);
    final_report;
  end
  initial begin
    #5000000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
